/* design/tfp_timer_flags.sv */
// Timer event flags, shared prescaler and external clock edge logic behind AXI4-Lite.
//
// Notes on behaviour
// - Timer-1 compare-C request only when mask, global enable and flag all set.
// - A capture pin event sets that timer's capture flag, bit 5.
// - With capture register as TOP, capture flag sets at TOP, not pin.
// - Compare flags set one timer clock after counter equals compare value.
// - A forced compare strobe never sets a compare flag.
// - Overflow flag sets on overflow; set point depends on waveform mode.
// - Executing the vector clears its capture, compare or overflow flag.
// - Writing one clears a flag; writing zero leaves it alone.
// - Clock select 1 counts on every system clock.
// - Prescaler taps divide by 8, 64, 256 and 1024, selectable per timer.
// - One free running prescaler serves timers 1, 2, 3 independently.
// - First prescaled count arrives 1 to divisor cycles after enable.
// - External pin is synchronised each clock, then edge detected.
// - Select 7 counts rising edges, select 6 counts falling edges.
// - Pin edge to count pulse takes 2 to 3 system clocks.
// - The external clock bypasses the prescaler undivided.
// - While sync hold mode is one, prescaler reset bits keep written values.
// - Writing sync hold mode zero while it is one clears both prescaler reset bits.
// - Shared prescaler reset resets all three timers' taps and self-clears when sync hold mode is zero.
// - Clock select zero stops the timer.
`timescale 1ns/100ps
`default_nettype none
`include "tfp_defines.svh"
module tfp_timer_flags
(
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             global_irq_en,
  input  wire tfp_pkg::tfp_evt_s t1_evt,
  input  wire tfp_pkg::tfp_evt_s t3_evt,
  input  wire logic [5:0]       flags_vec_ack,
  input  wire logic [5:0]       ext_flags_vec_ack,
  input  wire logic [2:0]       ext_count_pin,
  output logic [2:0]            timer_tick,
  output logic                  t1_cmp_c_irq
);
  // ----------------------------------------------------------------
  // State and next state
  // ----------------------------------------------------------------
  tfp_pkg::tfp_state_s st;
  tfp_pkg::tfp_state_s next_st;

  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  wsel;
  logic [7:0]  fl_set;
  logic [7:0]  fl_clr;
  logic [5:0]  ex_set;
  logic [5:0]  ex_clr;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [2:0]  cs_all [3];
  logic [2:0]  fall_edge;
  logic [2:0]  rise_edge;
  logic [3:0]  tap_hit;
  logic [2:0]  src_tick;

  assign s_axi_awready = (st.wr == tfp_pkg::TFP_IDLE) && s_axi_awvalid && s_axi_wvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_bvalid  = (st.wr == tfp_pkg::TFP_BRSP);
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign timer_tick    = st.tick;
  assign wr_fire       = s_axi_awready;
  assign rd_fire       = s_axi_arvalid && !st.rvalid;
  assign wsel          = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;

  assign cs_all[0] = st.cs1;
  assign cs_all[1] = st.cs2;
  assign cs_all[2] = st.cs3;

  // ----------------------------------------------------------------
  // Prescaler taps
  // ----------------------------------------------------------------
  // All taps come from the one shared divider, so timers on one tap tick together.
  always_comb
  begin
    tap_hit[0] = (st.presc[2:0] == `TFP_DIV8_LAST);
    tap_hit[1] = (st.presc[5:0] == `TFP_DIV64_LAST);
    tap_hit[2] = (st.presc[7:0] == `TFP_DIV256_LAST);
    tap_hit[3] = (st.presc == `TFP_DIV1024_LAST);
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Only the timer-1 compare-C request leaves the block; the other mask bits are only stored and read back.
  assign t1_cmp_c_irq = st.irq_mask[`TFP_BIT_T1_CMPC] && global_irq_en
                        && st.ext_flags[`TFP_BIT_T1_CMPC];

  // ----------------------------------------------------------------
  // Flag set and clear terms
  // ----------------------------------------------------------------
  always_comb
  begin
    fl_set = 8'h00;
    ex_set = 6'h00;
    fl_set[`TFP_BIT_T1_CAP]  = t1_evt.cap_is_top ? t1_evt.top_hit : t1_evt.cap_pin;
    ex_set[`TFP_BIT_T3_CAP]  = t3_evt.cap_is_top ? t3_evt.top_hit : t3_evt.cap_pin;
    // Compare flags use the matches delayed to the next timer tick; forces never enter.
    fl_set[`TFP_BIT_T1_CMPA] = st.m1_a[1];
    fl_set[`TFP_BIT_T1_CMPB] = st.m1_b[1];
    ex_set[`TFP_BIT_T1_CMPC] = st.m1_c[1];
    ex_set[`TFP_BIT_T3_CMPA] = st.m3_a[1];
    ex_set[`TFP_BIT_T3_CMPB] = st.m3_b[1];
    ex_set[`TFP_BIT_T3_CMPC] = st.m3_c[1];
    // The counter unit decodes the waveform mode into its overflow strobe.
    fl_set[`TFP_BIT_T1_OVF]  = t1_evt.overflow;
    ex_set[`TFP_BIT_T3_OVF]  = t3_evt.overflow;
    // Vector and write clears share one path, so both obey the set-wins rule.
    fl_clr = {2'b00, flags_vec_ack} & 8'h3C;
    ex_clr = ext_flags_vec_ack;
    if (wr_fire && (s_axi_awaddr == `TFP_ADDR_FLAGS))
    begin
      fl_clr = fl_clr | (wsel & 8'h3C);
    end
    if (wr_fire && (s_axi_awaddr == `TFP_ADDR_EXT_FLAGS))
    begin
      // Reserved bits 7:6 have no storage, so whatever is written there is dropped.
      ex_clr = ex_clr | wsel[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr == `TFP_ADDR_FLAGS)
    begin
      rd_val[7:0] = st.flags;
    end
    else if (s_axi_araddr == `TFP_ADDR_EXT_FLAGS)
    begin
      rd_val[5:0] = st.ext_flags;
    end
    else if (s_axi_araddr == `TFP_ADDR_SFC)
    begin
      rd_val[`TFP_BIT_SYNC_HOLD]  = st.sync_hold_mode;
      rd_val[`TFP_BIT_T0_PSR]     = st.t0_prescaler_reset;
      rd_val[`TFP_BIT_SHARED_PSR] = st.shared_prescaler_reset;
    end
    else if (s_axi_araddr == `TFP_ADDR_CTRL)
    begin
      rd_val[8:0] = {st.cs3, st.cs2, st.cs1};
    end
    else if (s_axi_araddr == `TFP_ADDR_MASK)
    begin
      rd_val[5:0] = st.irq_mask;
    end
    else if (s_axi_araddr == `TFP_ADDR_STATUS)
    begin
      rd_val[9:0]   = st.presc;
      rd_val[12:10] = st.tick;
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-timer clock source selection
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_src
      // Edge detection reads only the second sync stage and its delayed copy.
      logic pick;
      assign rise_edge[gi] = st.ext_s2[gi] && !st.ext_prev[gi];
      assign fall_edge[gi] = !st.ext_s2[gi] && st.ext_prev[gi];

      always_comb
      begin
        case (cs_all[gi])
          `TFP_CS_DIRECT:   pick = 1'b1;
          `TFP_CS_DIV8:     pick = tap_hit[0];
          `TFP_CS_DIV64:    pick = tap_hit[1];
          `TFP_CS_DIV256:   pick = tap_hit[2];
          `TFP_CS_DIV1024:  pick = tap_hit[3];
          `TFP_CS_EXT_FALL: pick = fall_edge[gi];
          `TFP_CS_EXT_RISE: pick = rise_edge[gi];
          default:          pick = 1'b0;
        endcase
        // A held prescaler reset halts prescaled timers; direct and external ones run on.
        if (st.shared_prescaler_reset && (cs_all[gi] > `TFP_CS_DIRECT)
            && (cs_all[gi] < `TFP_CS_EXT_FALL))
        begin
          pick = 1'b0;
        end
      end
      assign src_tick[gi] = pick;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.flags     = (st.flags & ~fl_clr) | fl_set;
    next_st.ext_flags = (st.ext_flags & ~ex_clr) | ex_set;

    // Three flops put the pulse 2 to 3 clocks after an asynchronous edge.
    next_st.ext_s1   = ext_count_pin;
    next_st.ext_s2   = st.ext_s1;
    next_st.ext_prev = st.ext_s2;

    // Free running divider; nothing in clock select stops it.
    next_st.presc = st.shared_prescaler_reset ? 10'h000 : st.presc + 10'h001;

    // Ticks are registered, so every count pulse lags its source by one system clock.
    next_st.tick = src_tick;

    // Match pipelines: bit 0 holds a seen match, bit 1 fires on the next tick of timer 1 or 3.
    next_st.m1_a = {st.tick[0] & st.m1_a[0], st.m1_a[0] & ~st.tick[0] | t1_evt.cmp_a, 1'b0};
    next_st.m1_b = {st.tick[0] & st.m1_b[0], st.m1_b[0] & ~st.tick[0] | t1_evt.cmp_b, 1'b0};
    next_st.m1_c = {st.tick[0] & st.m1_c[0], st.m1_c[0] & ~st.tick[0] | t1_evt.cmp_c, 1'b0};
    next_st.m3_a = {st.tick[2] & st.m3_a[0], st.m3_a[0] & ~st.tick[2] | t3_evt.cmp_a, 1'b0};
    next_st.m3_b = {st.tick[2] & st.m3_b[0], st.m3_b[0] & ~st.tick[2] | t3_evt.cmp_b, 1'b0};
    next_st.m3_c = {st.tick[2] & st.m3_c[0], st.m3_c[0] & ~st.tick[2] | t3_evt.cmp_c, 1'b0};
    next_st.m1_a = {1'b0, next_st.m1_a[2:1]};
    next_st.m1_b = {1'b0, next_st.m1_b[2:1]};
    next_st.m1_c = {1'b0, next_st.m1_c[2:1]};
    next_st.m3_a = {1'b0, next_st.m3_a[2:1]};
    next_st.m3_b = {1'b0, next_st.m3_b[2:1]};
    next_st.m3_c = {1'b0, next_st.m3_c[2:1]};

    // Reset bits self-clear unless sync hold keeps them.
    if (!st.sync_hold_mode)
    begin
      next_st.shared_prescaler_reset = 1'b0;
      next_st.t0_prescaler_reset     = 1'b0;
    end

    // Write channel.
    // Address and data are taken together, so no register ever sees half a write.
    case (st.wr)
      tfp_pkg::TFP_IDLE:
      begin
        if (wr_fire)
        begin
          next_st.wr    = tfp_pkg::TFP_BRSP;
          next_st.bresp = `TFP_RESP_OKAY;
          if (s_axi_awaddr == `TFP_ADDR_SFC)
          begin
            if (s_axi_wstrb[0])
            begin
              next_st.sync_hold_mode = wsel[`TFP_BIT_SYNC_HOLD];
              if (wsel[`TFP_BIT_SYNC_HOLD])
              begin
                next_st.shared_prescaler_reset = wsel[`TFP_BIT_SHARED_PSR];
                next_st.t0_prescaler_reset     = wsel[`TFP_BIT_T0_PSR];
              end
              else
              begin
                // Leaving hold releases all timers together in one cycle.
                next_st.shared_prescaler_reset = wsel[`TFP_BIT_SHARED_PSR];
                next_st.t0_prescaler_reset     = 1'b0;
                if (st.sync_hold_mode)
                begin
                  next_st.shared_prescaler_reset = 1'b0;
                end
              end
            end
          end
          else if (s_axi_awaddr == `TFP_ADDR_CTRL)
          begin
            if (s_axi_wstrb[0])
            begin
              next_st.cs1 = s_axi_wdata[2:0];
              next_st.cs2 = s_axi_wdata[5:3];
              next_st.cs3[1:0] = s_axi_wdata[7:6];
            end
            if (s_axi_wstrb[1])
            begin
              next_st.cs3[2] = s_axi_wdata[8];
            end
          end
          else if (s_axi_awaddr == `TFP_ADDR_MASK)
          begin
            if (s_axi_wstrb[0])
            begin
              next_st.irq_mask = s_axi_wdata[5:0];
            end
          end
          // Flag and status writes answer OKAY; flags clear elsewhere, status ignores them.
          else if ((s_axi_awaddr != `TFP_ADDR_FLAGS) && (s_axi_awaddr != `TFP_ADDR_EXT_FLAGS)
                   && (s_axi_awaddr != `TFP_ADDR_STATUS))
          begin
            next_st.bresp = `TFP_RESP_SLVERR;
          end
        end
      end
      tfp_pkg::TFP_BRSP:
      begin
        if (s_axi_bready)
        begin
          next_st.wr = tfp_pkg::TFP_IDLE;
        end
      end
      default:
      begin
        next_st.wr = tfp_pkg::TFP_IDLE;
      end
    endcase

    // Read channel; one read outstanding at a time.
    // Data are captured when the address is taken, so a later flag change cannot tear them.
    if (rd_fire)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_val;
      next_st.rresp  = rd_ok ? `TFP_RESP_OKAY : `TFP_RESP_SLVERR;
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset stops every timer: all selects read zero until software picks a source.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st           <= '0;
      st.flags     <= `TFP_FLAGS_RESET;
      st.ext_flags <= `TFP_EXT_RESET;
      st.wr        <= tfp_pkg::TFP_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

/* design/tfp_defines.svh */
// Register offsets, field positions, reset values and timing counts of the timer flag block.
`ifndef TFP_DEFINES_SVH
`define TFP_DEFINES_SVH
`define TFP_ADDR_FLAGS      8'h00
`define TFP_ADDR_EXT_FLAGS  8'h04
`define TFP_ADDR_SFC        8'h08
`define TFP_ADDR_CTRL       8'h0C
`define TFP_ADDR_MASK       8'h10
`define TFP_ADDR_STATUS     8'h14
`define TFP_FLAGS_RESET     8'h00
`define TFP_EXT_RESET       6'h00
`define TFP_BIT_T1_CAP      5
`define TFP_BIT_T1_CMPA     4
`define TFP_BIT_T1_CMPB     3
`define TFP_BIT_T1_OVF      2
`define TFP_BIT_T3_CAP      5
`define TFP_BIT_T3_CMPA     4
`define TFP_BIT_T3_CMPB     3
`define TFP_BIT_T3_OVF      2
`define TFP_BIT_T3_CMPC     1
`define TFP_BIT_T1_CMPC     0
`define TFP_BIT_SYNC_HOLD   7
`define TFP_BIT_T0_PSR      1
`define TFP_BIT_SHARED_PSR  0
`define TFP_CS_STOP         3'h0
`define TFP_CS_DIRECT       3'h1
`define TFP_CS_DIV8         3'h2
`define TFP_CS_DIV64        3'h3
`define TFP_CS_DIV256       3'h4
`define TFP_CS_DIV1024      3'h5
`define TFP_CS_EXT_FALL     3'h6
`define TFP_CS_EXT_RISE     3'h7
`define TFP_DIV8_LAST       3'h7
`define TFP_DIV64_LAST      6'h3F
`define TFP_DIV256_LAST     8'hFF
`define TFP_DIV1024_LAST    10'h3FF
`define TFP_RESP_OKAY       2'h0
`define TFP_RESP_SLVERR     2'h2
`endif

/* design/tfp_pkg.sv */
// Types shared by the timer flag and prescaler block.
`default_nettype none
package tfp_pkg;
  typedef enum logic [1:0] {
    TFP_IDLE = 2'b00,
    TFP_BRSP = 2'b01
  } tfp_wr_e;

  typedef struct packed {
    logic       cap_pin;
    logic       top_hit;
    logic       cap_is_top;
    logic       cmp_a;
    logic       cmp_b;
    logic       cmp_c;
    logic       overflow;
  } tfp_evt_s;

  typedef struct packed {
    logic [7:0] flags;
    logic [5:0] ext_flags;
    logic       sync_hold_mode;
    logic       shared_prescaler_reset;
    logic       t0_prescaler_reset;
    logic [2:0] cs1;
    logic [2:0] cs2;
    logic [2:0] cs3;
    logic [5:0] irq_mask;
    logic [9:0] presc;
    logic [2:0] ext_s1;
    logic [2:0] ext_s2;
    logic [2:0] ext_prev;
    logic [2:0] tick;
    logic [2:0] m1_a;
    logic [2:0] m1_b;
    logic [2:0] m1_c;
    logic [2:0] m3_a;
    logic [2:0] m3_b;
    logic [2:0] m3_c;
    tfp_wr_e    wr;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
  } tfp_state_s;
endpackage
`default_nettype wire

/* tb/tfp_timer_flags_props.sv */
// Checker for the register bus and compare-C request of the timer flag block.
`timescale 1ns/100ps
`default_nettype none
module tfp_timer_flags_props
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        global_irq_en,
  input wire logic [5:0]  ext_flags_vec_ack,
  input wire logic [2:0]  timer_tick,
  input wire logic        t1_cmp_c_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  property p_irq_en;
    t1_cmp_c_irq |-> global_irq_en;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("request without global enable");
  // A tick one cycle before the ack may legally set the flag again, so it is excluded.
  property p_irq_clr;
    ext_flags_vec_ack[0] && !$past(timer_tick[0]) |=> !t1_cmp_c_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("request after vector clear");
  property p_wr_ans;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read response");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_rdy;
    s_axi_rvalid && s_axi_rready |=> s_axi_arready;
  endproperty
  a_ar_rdy: assert property (p_ar_rdy) else $error("read address not ready after response");
endmodule
bind tfp_timer_flags tfp_timer_flags_props u_tfp_timer_flags_props
  (.mclk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .global_irq_en, .ext_flags_vec_ack,
   .timer_tick, .t1_cmp_c_irq);
`default_nettype wire

/* tb/tfp_ext_src.sv */
// Behavioural external count clock source for the three timer pins.
`timescale 1ns/100ps
`default_nettype none
module tfp_ext_src
(
  input wire logic       mclk,
  input wire logic       run,
  input wire logic [3:0] half,
  output logic [2:0]     pin
);
  logic [3:0] cnt = 4'h0;
  logic [2:0] lvl = 3'h0;
  assign pin = lvl;
  // The pin stands still while stopped, so select changes see a steady level.
  always @(posedge mclk)
    if (!run)
      cnt <= 4'h0;
    else if (cnt == half)
    begin
      cnt <= 4'h0;
      lvl <= ~lvl;
    end
    else
      cnt <= cnt + 4'h1;
endmodule
`default_nettype wire

/* tb/tfp_timer_flags_tb.sv */
// Self-checking bench for the timer flag and prescaler block.
`timescale 1ns/100ps
`default_nettype none
`include "tfp_defines.svh"
module tfp_timer_flags_tb;
  logic              mclk;
  logic              rst_b = 1'b0;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata = 32'h0000_0000;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready = 1'b0;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready = 1'b0;
  logic              global_irq_en = 1'b0;
  tfp_pkg::tfp_evt_s t1_evt = '0;
  tfp_pkg::tfp_evt_s t3_evt = '0;
  logic [5:0]        flags_vec_ack = 6'h00;
  logic [5:0]        ext_flags_vec_ack = 6'h00;
  logic [2:0]        ext_count_pin;
  logic [2:0]        timer_tick;
  logic              t1_cmp_c_irq;
  logic              run = 1'b0;
  logic [3:0]        hv;
  int                n_fail = 0;
  int                tests_run = 0;
  assign hv = {s_axi_arready, s_axi_rvalid, s_axi_bvalid, s_axi_awready};
  tfp_timer_flags u_tfp_timer_flags (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .global_irq_en, .t1_evt, .t3_evt, .flags_vec_ack, .ext_flags_vec_ack,
    .ext_count_pin, .timer_tick, .t1_cmp_c_irq);
  tfp_ext_src u_tfp_ext_src (.mclk, .run, .half(4'h3), .pin(ext_count_pin));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Polls at the falling edge, where outputs are settled, then ends on the taking edge.
  task automatic hs(input int k);
    int i;
    i = 0;
    do
    begin
      @(negedge mclk);
      i++;
    end
    while (hv[k] !== 1'b1 && i < 100);
    if (hv[k] !== 1'b1)
    begin
      n_fail++;
      finish_test();
    end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hs(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge mclk);
    s_axi_bready <= 1'b1;
    hs(1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(`TFP_RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hs(3);
    s_axi_arvalid <= 1'b0;
    @(posedge mclk);
    s_axi_rready <= 1'b1;
    hs(2);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic ev(input logic [6:0] a, input logic [6:0] b, input logic [5:0] k,
                    input logic [5:0] e);
    t1_evt <= a;
    t3_evt <= b;
    flags_vec_ack <= k;
    ext_flags_vec_ack <= e;
    @(posedge mclk);
    t1_evt <= '0;
    t3_evt <= '0;
    flags_vec_ack <= 6'h00;
    ext_flags_vec_ack <= 6'h00;
    @(posedge mclk);
  endtask
  task automatic wtick(input int k, output int c);
    c = 0;
    do
    begin
      @(negedge mclk);
      c++;
    end
    while (timer_tick[k] !== 1'b1 && c < 2100);
    if (c == 2100)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic per(input int k, input int n);
    int c;
    wtick(k, c);
    chk(32'(c <= n + 1), 32'h0000_0001);
    wtick(k, c);
    chk(32'(c), 32'(n));
    @(posedge mclk);
  endtask
  //----------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------
  task automatic s_flags;
    rd(`TFP_ADDR_FLAGS, 32'h0000_0000, `TFP_RESP_OKAY);
    rd(`TFP_ADDR_EXT_FLAGS, 32'h0000_0000, `TFP_RESP_OKAY);
    rd(8'h18, 32'h0000_0000, `TFP_RESP_SLVERR);
    ev(7'h41, 7'h41, 6'h00, 6'h00);
    rd(`TFP_ADDR_FLAGS, 32'h0000_0024, `TFP_RESP_OKAY);
    rd(`TFP_ADDR_EXT_FLAGS, 32'h0000_0024, `TFP_RESP_OKAY);
    wr(`TFP_ADDR_FLAGS, 32'h0000_0004);
    rd(`TFP_ADDR_FLAGS, 32'h0000_0020, `TFP_RESP_OKAY);
    ev(7'h01, 7'h00, 6'h24, 6'h20);
    rd(`TFP_ADDR_FLAGS, 32'h0000_0004, `TFP_RESP_OKAY);
    rd(`TFP_ADDR_EXT_FLAGS, 32'h0000_0004, `TFP_RESP_OKAY);
    wr(`TFP_ADDR_EXT_FLAGS, 32'h0000_0004);
    wr(`TFP_ADDR_FLAGS, 32'h0000_0004);
    ev(7'h00, 7'h50, 6'h00, 6'h00);
    rd(`TFP_ADDR_EXT_FLAGS, 32'h0000_0000, `TFP_RESP_OKAY);
    ev(7'h00, 7'h30, 6'h00, 6'h00);
    rd(`TFP_ADDR_EXT_FLAGS, 32'h0000_0020, `TFP_RESP_OKAY);
    wr(`TFP_ADDR_EXT_FLAGS, 32'h0000_0020);
  endtask
  task automatic s_cmp;
    ev(7'h0E, 7'h0E, 6'h00, 6'h00);
    chk(32'(timer_tick), 32'h0000_0000);
    rd(`TFP_ADDR_FLAGS, 32'h0000_0000, `TFP_RESP_OKAY);
    wr(`TFP_ADDR_CTRL, 32'h0000_0049);
    @(negedge mclk);
    chk(32'(timer_tick), 32'h0000_0007);
    @(posedge mclk);
    rd(`TFP_ADDR_FLAGS, 32'h0000_0018, `TFP_RESP_OKAY);
    rd(`TFP_ADDR_EXT_FLAGS, 32'h0000_001B, `TFP_RESP_OKAY);
    wr(`TFP_ADDR_MASK, 32'h0000_0001);
    global_irq_en <= 1'b1;
    @(negedge mclk);
    chk(32'(t1_cmp_c_irq), 32'h0000_0001);
    @(posedge mclk);
    global_irq_en <= 1'b0;
    @(negedge mclk);
    chk(32'(t1_cmp_c_irq), 32'h0000_0000);
    @(posedge mclk);
    global_irq_en <= 1'b1;
    wr(`TFP_ADDR_CTRL, 32'h0000_0000);
    ev(7'h00, 7'h00, 6'h00, 6'h01);
    chk(32'(t1_cmp_c_irq), 32'h0000_0000);
    wr(`TFP_ADDR_FLAGS, 32'h0000_0018);
    wr(`TFP_ADDR_EXT_FLAGS, 32'h0000_001A);
    rd(`TFP_ADDR_EXT_FLAGS, 32'h0000_0000, `TFP_RESP_OKAY);
  endtask
  task automatic s_presc;
    int dv [4] = '{8, 64, 256, 1024};
    for (int j = 0; j < 4; j++)
    begin
      wr(`TFP_ADDR_CTRL, 32'h0000_0081 | 32'((j + 2) << 3));
      per(1, dv[j]);
      per(2, 8);
    end
  endtask
  task automatic s_sync;
    int c;
    wr(`TFP_ADDR_CTRL, 32'h0000_0092);
    wr(`TFP_ADDR_SFC, 32'h0000_0081);
    rd(`TFP_ADDR_SFC, 32'h0000_0081, `TFP_RESP_OKAY);
    rd(`TFP_ADDR_STATUS, 32'h0000_0000, `TFP_RESP_OKAY);
    wr(`TFP_ADDR_SFC, 32'h0000_0000);
    rd(`TFP_ADDR_SFC, 32'h0000_0000, `TFP_RESP_OKAY);
    wtick(0, c);
    chk(32'(timer_tick), 32'h0000_0007);
    @(posedge mclk);
    wr(`TFP_ADDR_SFC, 32'h0000_0001);
    rd(`TFP_ADDR_SFC, 32'h0000_0000, `TFP_RESP_OKAY);
  endtask
  task automatic s_ext;
    int r = 0;
    int f = 0;
    int lr = -100;
    int t [3] = '{0, 0, 0};
    logic p = 1'b0;
    wr(`TFP_ADDR_CTRL, 32'h0000_0037);
    run <= 1'b1;
    for (int c = 0; c < 96; c++)
    begin
      @(posedge mclk);
      if (c == 80)
        run <= 1'b0;
      @(negedge mclk);
      if (ext_count_pin[0] && !p)
        r++;
      if (ext_count_pin[0] && !p)
        lr = c;
      if (!ext_count_pin[0] && p)
        f++;
      p = ext_count_pin[0];
      for (int k = 0; k < 3; k++)
        t[k] += timer_tick[k];
      if (timer_tick[0] === 1'b1)
        chk(32'((c - lr) inside {3, 4}), 32'h0000_0001);
    end
    chk(32'(t[0]), 32'(r));
    chk(32'(t[1]), 32'(f));
    chk(32'(t[2]), 32'h0000_0000);
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    s_flags();
    s_cmp();
    s_presc();
    s_sync();
    s_ext();
    finish_test();
  end
endmodule
`default_nettype wire
